// ===== inc/efi_defs.svh
`ifndef EFI_DEFS_SVH
`define EFI_DEFS_SVH

// ==========================================
// timing
`define EFI_CLK_HZ 20000000
`define EFI_SAMPLE_HZ 4000
`define EFI_SSI_MAX_HZ 500000
// least half period, rounded up to whole cycles
`define EFI_SSI_HALF_CYC ((`EFI_CLK_HZ + 2 * `EFI_SSI_MAX_HZ - 1) / (2 * `EFI_SSI_MAX_HZ))

// ==========================================
// serial word layout
`define EFI_SSI_BITS 25
`define EFI_SSI_REV_BITS 12
`define EFI_SSI_ANG_BITS 13
`define EFI_SSI_REV_MSB 24
`define EFI_SSI_REV_LSB 13
`define EFI_SSI_ANG_MSB 12

// ==========================================
// line count range
`define EFI_LINES_MIN 14'h0020
`define EFI_LINES_MAX 14'h2000

// ==========================================
// reset values
`define EFI_SSI_CLK_IDLE 1'b1
`define EFI_COUNT_RST 16'h0000

`endif

// ===== inc/efi_pkg.sv
`include "efi_defs.svh"

package efi_pkg;

    typedef enum logic [1:0] {SSI_IDLE, SSI_LOW, SSI_HIGH} efi_ssi_st_t;

    typedef struct packed {
        logic primed;
        logic [1:0] ab;
        logic r;
        logic [15:0] angle;
        logic [15:0] revs;
        logic err;
    } efi_quad_st_t;

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        efi_ssi_st_t st;
        logic [15:0] tick_cnt;
        logic [7:0] half_cnt;
        logic [4:0] bit_cnt;
        logic [`EFI_SSI_BITS-1:0] shreg;
        logic [`EFI_SSI_BITS-1:0] ssi_word;
        logic ssi_clk;
        logic smp_valid;
        logic [15:0] pf_angle;
        logic [15:0] pf_revs;
        logic [15:0] cm_angle;
        logic [15:0] cm_revs;
    } efi_top_st_t;

    function automatic logic [`EFI_SSI_BITS-1:0] efi_gray2bin(input logic [`EFI_SSI_BITS-1:0] g);
        logic [`EFI_SSI_BITS-1:0] b;
        b = g;
        for (int i = `EFI_SSI_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ===== inc/efi_quad_if.sv
interface efi_quad_if;
    logic a;
    logic b;
    logic r;
    logic [13:0] lines;
    logic [15:0] angle;
    logic [15:0] revs;
    logic err;
    modport dec (input a, input b, input r, input lines, output angle, output revs, output err);
    modport user (output a, output b, output r, output lines, input angle, input revs, input err);
endinterface

// ===== logic/efi_quad.sv
`include "efi_defs.svh"

module efi_quad import efi_pkg::*; #(
    parameter bit HAS_REF = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    efi_quad_if.dec qi
);

    efi_quad_st_t q;
    efi_quad_st_t d;
    logic [1:0] cur;
    logic [15:0] lim;
    logic up_ev;
    logic dn_ev;
    logic bad_ev;
    logic ref_ev;

    // ==========================================
    // decode
    always_comb begin
        cur = {qi.a, qi.b};
        lim = {qi.lines, 2'b00} - 16'h0001;
        up_ev = q.primed && ({q.ab, cur} inside {4'h2, 4'hB, 4'hD, 4'h4});
        dn_ev = q.primed && ({q.ab, cur} inside {4'h1, 4'h7, 4'hE, 4'h8});
        bad_ev = q.primed && ((q.ab ^ cur) == 2'h3);
        ref_ev = HAS_REF && qi.r && !q.r;
        d = q;
        d.primed = 1'b1;
        d.ab = cur;
        d.r = qi.r;
        d.err = bad_ev;
        if (up_ev) begin
            // wrap at four edges per line, one revolution
            if (q.angle >= lim) begin
                d.angle = `EFI_COUNT_RST;
                d.revs = q.revs + 16'h0001;
            end else begin
                d.angle = q.angle + 16'h0001;
            end
        end else if (dn_ev) begin
            if (q.angle == 16'h0000) begin
                d.angle = lim;
                d.revs = q.revs - 16'h0001;
            end else begin
                d.angle = q.angle - 16'h0001;
            end
        end
        if (ref_ev) begin
            d.angle = `EFI_COUNT_RST;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign qi.angle = q.angle;
    assign qi.revs = q.revs;
    assign qi.err = q.err;

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    up_count_a: assert property (up_ev && !ref_ev && q.angle < lim |=> q.angle == $past(q.angle) + 16'h0001)
        else $error("angle did not step up");
    down_wrap_a: assert property (dn_ev && !ref_ev && q.angle == 16'h0000 |=>
        q.angle == $past(lim) && q.revs == $past(q.revs) - 16'h0001)
        else $error("reverse wrap wrong");
    bad_edge_a: assert property (bad_ev |=> q.err ##1 (!q.err || $past(bad_ev)))
        else $error("double edge not flagged");
    ref_zero_a: assert property (qi.r && !q.r |=> (q.angle == 16'h0000) == HAS_REF || $past(up_ev || dn_ev))
        else $error("reference handling wrong");

endmodule

// ===== logic/efi_top.sv
`include "efi_defs.svh"

// Operation
// - primary port runs either quadrature track mode or serial absolute mode
// - line count per revolution settable 32 to 8192; position scaled by it
// - serial mode reads Gray-coded multiturn word; device converts it to binary
// - serial word is 25 bits, msb first: 12 revolution bits, 13 angle bits
// - track and serial signals up to 500 kHz are followed without loss
// - position is sampled at 4 kHz in both modes
// - tracks A, B and reference R; serial mode uses clock and data pairs
// - with second encoder, primary position only feeds the position controller
// - with second encoder, its position drives commutation and speed loop
// - second encoder counted on two control inputs alongside primary port
// - second encoder uses plain A and B only, no reference evaluation
module efi_top import efi_pkg::*; #(
    parameter int SAMPLE_CYC = `EFI_CLK_HZ / `EFI_SAMPLE_HZ,
    parameter int SSI_HALF = `EFI_SSI_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mode_ssi,
    input wire logic sec_enc_en,
    input wire logic [13:0] lines_per_rev,
    input wire logic [13:0] sec_lines_per_rev,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_r,
    input wire logic ssi_data,
    output logic ssi_clk,
    input wire logic ctrl_input_track_a,
    input wire logic ctrl_input_track_b,
    output logic sample_valid,
    output logic [15:0] pos_fb_angle,
    output logic [15:0] pos_fb_revs,
    output logic [15:0] cmt_angle,
    output logic [15:0] cmt_revs,
    output logic enc_err
);

    efi_top_st_t q;
    efi_top_st_t d;
    logic tick;
    logic last_half;
    logic [`EFI_SSI_BITS-1:0] ssi_bin;
    logic [15:0] src_angle;
    logic [15:0] src_revs;

    efi_quad_if prim_if ();
    efi_quad_if sec_if ();

    // ==========================================
    // line count clamp
    function automatic logic [13:0] clamp_lines(input logic [13:0] l);
        logic [13:0] c;
        c = l;
        if (l < `EFI_LINES_MIN) begin
            c = `EFI_LINES_MIN;
        end else if (l > `EFI_LINES_MAX) begin
            c = `EFI_LINES_MAX;
        end
        return c;
    endfunction

    // ==========================================
    // quadrature counters
    assign prim_if.a = q.sync2[5];
    assign prim_if.b = q.sync2[4];
    assign prim_if.r = q.sync2[3];
    assign prim_if.lines = clamp_lines(lines_per_rev);
    assign sec_if.a = q.sync2[1];
    assign sec_if.b = q.sync2[0];
    assign sec_if.r = 1'b0;
    assign sec_if.lines = clamp_lines(sec_lines_per_rev);

    efi_quad #(.HAS_REF(1'b1)) u_prim (
        .sys_clk(sys_clk),
        .rst(rst),
        .qi(prim_if)
    );

    // second counter runs whatever the primary mode is
    efi_quad #(.HAS_REF(1'b0)) u_sec (
        .sys_clk(sys_clk),
        .rst(rst),
        .qi(sec_if)
    );

    // ==========================================
    // sampling and serial master
    always_comb begin
        tick = (q.tick_cnt == 16'(SAMPLE_CYC - 1));
        last_half = (q.half_cnt == 8'(SSI_HALF - 1));
        ssi_bin = efi_gray2bin(q.ssi_word);
        if (mode_ssi) begin
            src_revs = {4'h0, ssi_bin[`EFI_SSI_REV_MSB:`EFI_SSI_REV_LSB]};
            src_angle = {3'h0, ssi_bin[`EFI_SSI_ANG_MSB:0]};
        end else begin
            src_revs = prim_if.revs;
            src_angle = prim_if.angle;
        end
        d = q;
        // sync1 feeds sync2 only, pins are asynchronous to sys_clk
        d.sync1 = {enc_a, enc_b, enc_r, ssi_data, ctrl_input_track_a, ctrl_input_track_b};
        d.sync2 = q.sync1;
        d.smp_valid = 1'b0;
        d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
        if (tick) begin
            d.smp_valid = 1'b1;
            d.pf_angle = src_angle;
            d.pf_revs = src_revs;
            d.cm_angle = sec_enc_en ? sec_if.angle : src_angle;
            d.cm_revs = sec_enc_en ? sec_if.revs : src_revs;
        end
        case (q.st)
            SSI_IDLE: begin
                d.ssi_clk = `EFI_SSI_CLK_IDLE;
                if (tick && mode_ssi) begin
                    d.st = SSI_LOW;
                    d.ssi_clk = 1'b0;
                    d.half_cnt = 8'h00;
                    d.bit_cnt = 5'h00;
                end
            end
            SSI_LOW: begin
                d.half_cnt = q.half_cnt + 8'h01;
                if (last_half) begin
                    // data settled during the low half, taken at the rising edge
                    d.st = SSI_HIGH;
                    d.ssi_clk = 1'b1;
                    d.half_cnt = 8'h00;
                    d.shreg = {q.shreg[`EFI_SSI_BITS-2:0], q.sync2[2]};
                    d.bit_cnt = q.bit_cnt + 5'h01;
                end
            end
            SSI_HIGH: begin
                d.half_cnt = q.half_cnt + 8'h01;
                if (last_half) begin
                    d.half_cnt = 8'h00;
                    if (q.bit_cnt == 5'(`EFI_SSI_BITS)) begin
                        d.st = SSI_IDLE;
                        d.ssi_word = q.shreg;
                    end else begin
                        d.st = SSI_LOW;
                        d.ssi_clk = 1'b0;
                    end
                end
            end
            default: begin
                d.st = SSI_IDLE;
                d.ssi_clk = `EFI_SSI_CLK_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.ssi_clk <= `EFI_SSI_CLK_IDLE;
        end else begin
            q <= d;
        end
    end

    assign ssi_clk = q.ssi_clk;
    assign sample_valid = q.smp_valid;
    assign pos_fb_angle = q.pf_angle;
    assign pos_fb_revs = q.pf_revs;
    assign cmt_angle = q.cm_angle;
    assign cmt_revs = q.cm_revs;
    assign enc_err = prim_if.err | sec_if.err;

    // ==========================================
    // checks
    logic [7:0] lo_run;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lo_run <= 8'h00;
        end else begin
            lo_run <= q.ssi_clk ? 8'h00 : lo_run + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence burst_start_s;
        q.st == SSI_IDLE && tick && mode_ssi;
    endsequence

    sequence burst_end_s;
        q.st == SSI_HIGH && last_half && q.bit_cnt == 5'h19;
    endsequence

    burst_low_a: assert property (burst_start_s |=> !ssi_clk [*8])
        else $error("burst did not start with a low clock");
    burst_done_a: assert property (burst_end_s |=> q.st == SSI_IDLE && ssi_clk && q.ssi_word == $past(q.shreg))
        else $error("burst did not end after 25 bits");
    low_width_a: assert property ($rose(ssi_clk) |-> $past(lo_run) == 8'(SSI_HALF - 1))
        else $error("clock low phase has wrong width");
    idle_high_a: assert property (q.st == SSI_IDLE |-> ssi_clk)
        else $error("serial clock low while idle");
    track_no_burst_a: assert property (!mode_ssi && q.st == SSI_IDLE |=> q.st == SSI_IDLE)
        else $error("burst started in track mode");
    sample_rate_a: assert property (sample_valid |-> $past(q.tick_cnt) == 16'(SAMPLE_CYC - 1))
        else $error("sample spacing wrong");
    pos_track_a: assert property (sample_valid && !$past(mode_ssi) |-> pos_fb_angle == $past(prim_if.angle))
        else $error("position feedback not from primary counter");
    pos_serial_a: assert property (sample_valid && $past(mode_ssi) |->
        pos_fb_revs == {4'h0, $past(ssi_bin[24:13])} && pos_fb_angle == {3'h0, $past(ssi_bin[12:0])})
        else $error("serial word split or decode wrong");
    cmt_second_a: assert property (sample_valid && $past(sec_enc_en) |->
        cmt_angle == $past(sec_if.angle) && cmt_revs == $past(sec_if.revs))
        else $error("commutation not from second encoder");

endmodule

// ===== verif/efi_enc_model.sv
// ==========================================
// encoder model: quadrature tracks plus serial absolute word
module efi_enc_model #(
    parameter bit HAS_REF = 1'b1
) (
    input wire logic ssi_clk,
    input wire logic [24:0] bin_word,
    output logic a,
    output logic b,
    output logic r,
    output logic data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph = 2'h0;
    logic [24:0] gray;
    int idx = -1;
    initial begin
        a = 1'b0;
        b = 1'b0;
        r = 1'b0;
        data = 1'b1;
    end
    assign gray = bin_word ^ (bin_word >> 1);
    // ==========================================
    // serial side: new bit on each falling clock, msb first
    always @(negedge ssi_clk) begin
        if (idx < 0) begin
            idx = 24;
        end
        data = gray[idx];
        idx = idx - 1;
    end
    // monoflop: line held low after the word, then back to idle high
    always @(posedge ssi_clk) begin
        if (idx < 0) begin
            data = 1'b0;
            #2000 data = 1'b1;
        end
    end
    // ==========================================
    // track side: 500 ns per edge keeps the track rate at 500 kHz
    task automatic step(input bit up, input int n);
        for (int i = 0; i < n; i++) begin
            #500;
            ph = up ? ph + 2'h1 : ph - 2'h1;
            a = ph[1] ^ ph[0];
            b = ph[1];
        end
    endtask
    // both tracks at once: an illegal edge on purpose
    task automatic glitch();
        #500;
        ph = ph + 2'h2;
        a = ~a;
        b = ~b;
    endtask
    task automatic refp();
        #500 r = HAS_REF;
        #500 r = 1'b0;
    endtask
endmodule

// ===== verif/testbench.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 1200;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic mode_ssi = 1'b0;
    logic sec_enc_en = 1'b0;
    logic [13:0] lpr = 14'h0020;
    logic [13:0] slpr = 14'h2000;
    logic [24:0] word = 25'h0000000;
    logic a, b, r, d, sa, sb, ssi_clk, sv, err, prev_sc;
    logic [15:0] pfa, pfr, ca, cr;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int rises = 0;
    int falls = 0;
    int errs = 0;
    int last_sv = 0;
    int sv_gap = 0;

    always #25 sys_clk = ~sys_clk;

    // half period of 8 keeps the burst at 400 cycles and the low phase as long as the burst check wants
    efi_top #(.SAMPLE_CYC(SC), .SSI_HALF(8)) u_efi_top (.sys_clk(sys_clk), .rst(rst), .mode_ssi(mode_ssi),
        .sec_enc_en(sec_enc_en), .lines_per_rev(lpr), .sec_lines_per_rev(slpr), .enc_a(a), .enc_b(b),
        .enc_r(r), .ssi_data(d), .ssi_clk(ssi_clk), .ctrl_input_track_a(sa), .ctrl_input_track_b(sb),
        .sample_valid(sv), .pos_fb_angle(pfa), .pos_fb_revs(pfr), .cmt_angle(ca), .cmt_revs(cr),
        .enc_err(err));
    efi_enc_model u_efi_enc_model (.ssi_clk(ssi_clk), .bin_word(word), .a(a), .b(b), .r(r), .data(d));
    // second encoder has no reference track and no serial side
    efi_enc_model #(.HAS_REF(1'b0)) u_efi_enc_model_2 (.ssi_clk(1'b1), .bin_word(25'h0000000), .a(sa),
        .b(sb), .r(), .data());

    // ==========================================
    // monitor and timeout
    always @(posedge sys_clk) begin
        cyc++;
        if (ssi_clk === 1'b1 && prev_sc === 1'b0) rises++;
        if (ssi_clk === 1'b0 && prev_sc === 1'b1) falls++;
        prev_sc = ssi_clk;
        if (err === 1'b1) errs++;
        if (sv === 1'b1) begin
            sv_gap = cyc - last_sv;
            last_sv = cyc;
        end
        if (cyc > 40000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ends at a falling edge with fresh outputs
    task automatic wait_sv(input int k);
        repeat (k) begin
            @(negedge sys_clk);
            while (sv !== 1'b1) @(negedge sys_clk);
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        repeat (5) @(negedge sys_clk);
        `CHK({ssi_clk, sv, err, pfa, cr}, {1'b1, 1'b0, 1'b0, 32'h00000000})
        rst = 1'b0;
    endtask

    task automatic t_quad();
        falls = 0;
        u_efi_enc_model.step(1'b1, 130);
        wait_sv(2);
        `CHK({pfr, pfa}, {16'h0001, 16'h0002})
        `CHK({cr, ca}, {16'h0001, 16'h0002})
        u_efi_enc_model.step(1'b0, 3);
        wait_sv(2);
        `CHK({pfr, pfa}, {16'h0000, 16'h007F})
        `CHK(sv_gap, SC)
        `CHK(falls, 0)
    endtask

    task automatic t_ref_err();
        u_efi_enc_model.step(1'b1, 5);
        u_efi_enc_model.refp();
        wait_sv(2);
        `CHK({pfr, pfa}, {16'h0001, 16'h0000})
        errs = 0;
        u_efi_enc_model.glitch();
        wait_sv(2);
        `CHK(errs, 1)
        `CHK(pfa, 16'h0000)
    endtask

    task automatic t_sec();
        sec_enc_en = 1'b1;
        u_efi_enc_model_2.step(1'b0, 1);
        u_efi_enc_model.step(1'b1, 3);
        wait_sv(2);
        `CHK({cr, ca}, {16'hFFFF, 16'h7FFF})
        `CHK(pfa, 16'h0003)
        u_efi_enc_model.refp();
        wait_sv(2);
        `CHK({pfa, ca}, {16'h0000, 16'h7FFF})
    endtask

    task automatic t_ssi();
        sec_enc_en = 1'b0;
        mode_ssi = 1'b1;
        word = {12'hA5C, 13'h1234};
        wait_sv(2);
        rises = 0;
        wait_sv(1);
        `CHK(rises, 25)
        `CHK({pfr, pfa}, {16'h0A5C, 16'h1234})
        word = {12'h801, 13'h1001};
        wait_sv(2);
        `CHK({pfr, pfa}, {16'h0801, 16'h1001})
        `CHK(sv_gap, SC)
    endtask

    initial begin
        t_reset();
        t_quad();
        t_ref_err();
        t_sec();
        t_ssi();
        results();
    end
endmodule
